//--- adc_source_model.sv
// Behavioural model of the converters that drive the four sample buses.
// Assumes the bench calls put() just after a falling clock edge.
`timescale 1ns/1ps
module adc_source_model
  import input_fe_pkg::*;
(
  // Sample buses and their active-low enables
  output logic [BUS_W-1:0] bus_a_out,
  output logic [BUS_W-1:0] bus_b_out,
  output logic [BUS_W-1:0] bus_c_out,
  output logic [BUS_W-1:0] bus_d_out,
  output logic [3:0]       enable_n_out
);
  // ==========================================================================
  // Drive
  initial begin
    bus_a_out    = '0;
    bus_b_out    = '0;
    bus_c_out    = '0;
    bus_d_out    = '0;
    enable_n_out = 4'hF;
  end

  // All 17 lines are always driven, so extended float modes see the top bit
  task put(input int b, input logic [BUS_W-1:0] v, input logic en);
    logic [3:0] n;
    // Built aside so the enable lines change only once per call
    n    = 4'hF;
    n[b] = ~en;
    case (b)
      0: bus_a_out = v;
      1: bus_b_out = v;
      2: bus_c_out = v;
      default: bus_d_out = v;
    endcase
    enable_n_out = n;
  endtask : put
endmodule : adc_source_model

//--- channel_input_select_format.sv
// Four-channel input front end: per-channel source select, enable
// generation, real/complex capture, sideband and format conversion.
// Assumes all inputs are synchronous to ref_clk_in and that the processor
// presents one write per cycle on the write port.
//
// Function
// - Channel nibble 0 to 3 routes an indirect write to that channel.
// - Nibble F writes the same register in all four channels at once.
// - Bit 24 picks upper or lower sideband, only in complex mode.
// - Complex: I on enable; Q one clock later if bit 23, else two.
// - Bit 22 selects complex input when set, real input when clear.
// - Bit 21 realigns oscillator enables to data enables; clear keeps legacy delay.
// - Bits 20:18 cap the floating point exponent; 111 means no cap.
// - Bit 17 enables extended float modes; source drives seventeenth bit.
// - Bit 16 is the third float format select, decoded with bits 8:7.
// - Bits 15:13 codes 000 to 011 select buses A to D.
// - Test register loads via its global address and feeds selected channels.
// - Bit 12 set takes the test enable from bit 11.
// - Bit 12 clear: each strobe write makes one single-cycle test enable.
// - Bit 11 is an active-low test enable: 0 enabled, 1 disabled.
// - Bit 10: 0 two's complement, 1 offset binary input.
// - Bit 9: 0 fixed point, 1 floating point mantissa/exponent split.
// - Bits 8:7 are the two low float mantissa size select bits.
// - Gated mode advances oscillator and CIC only on enabled cycles.
`timescale 1ns/1ps
module channel_input_select_format
  import input_fe_pkg::*;
(
  // Clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          rst_in,
  // Processor write port
  input  wire logic                          wr_en_in,
  input  wire logic                          wr_global_in,
  input  wire logic [15:0]                   wr_addr_in,
  input  wire logic [31:0]                   wr_data_in,
  // Processor readback
  input  wire logic [1:0]                    rd_chan_in,
  output logic      [31:0]                   cfg_rd_out,
  // Parallel sample buses
  input  wire logic [BUS_W-1:0]              bus_a_in,
  input  wire logic [BUS_W-1:0]              bus_b_in,
  input  wire logic [BUS_W-1:0]              bus_c_in,
  input  wire logic [BUS_W-1:0]              bus_d_in,
  input  wire logic [3:0]                    sample_enable_n_in,
  // Per-channel samples toward the mixer/CIC stage
  output logic      [NUM_CH-1:0][OUT_W-1:0]  sample_i_out,
  output logic      [NUM_CH-1:0][OUT_W-1:0]  sample_q_out,
  output logic      [NUM_CH-1:0]             sample_valid_out,
  output logic      [NUM_CH-1:0]             osc_advance_out
);

  // ==========================================================================
  // Write decode
  function automatic logic chan_sel(input logic [3:0] nib, input int ch);
    chan_sel = (nib == CH_BCAST) || (nib == 4'(ch));
  endfunction : chan_sel

  function automatic logic glob_hit(input logic en, input logic glob,
                                    input logic [15:0] addr, input logic [15:0] target);
    glob_hit = en && glob && (addr == target);
  endfunction : glob_hit

  logic [3:0]       chan_nib;
  logic             cfg_hit;
  logic             strobe_hit;
  logic [31:0]      cfg_q [NUM_CH];
  logic [BUS_W-1:0] test_data_q;
  logic             test_strobe_q;
  logic [31:0]      cfg_rd_q;

  assign chan_nib   = wr_addr_in[CH_NIB_HI:CH_NIB_LO];
  assign cfg_hit    = wr_en_in && !wr_global_in && (wr_addr_in[CH_NIB_LO-1:0] == REG_INPUT_CFG);
  assign strobe_hit = glob_hit(wr_en_in, wr_global_in, wr_addr_in, GADDR_TEST_STROBE);

  // ==========================================================================
  // Channel configuration registers
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cfg_q[c] <= CFG_RESET;
      end
    end else if (cfg_hit) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (chan_sel(chan_nib, c)) begin
          cfg_q[c] <= wr_data_in;
        end
      end
    end
  end

  // ==========================================================================
  // Processor test input register and its strobe
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      test_data_q <= '0;
    end else if (glob_hit(wr_en_in, wr_global_in, wr_addr_in, GADDR_TEST_DATA)) begin
      test_data_q <= wr_data_in[BUS_W-1:0];
    end
  end

  // High for one clock per clock that software holds a write on the address
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      test_strobe_q <= 1'b0;
    end else begin
      test_strobe_q <= strobe_hit;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_rd_q <= CFG_RESET;
    end else begin
      cfg_rd_q <= cfg_q[rd_chan_in];
    end
  end

  assign cfg_rd_out = cfg_rd_q;

  // ==========================================================================
  // Source and enable select
  logic [BUS_W-1:0] raw_c  [NUM_CH];
  logic [OUT_W-1:0] conv_c [NUM_CH];
  logic [NUM_CH-1:0] en_c;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      unique case (cfg_q[c][B_SRC_HI:B_SRC_LO])
        SRC_BUS_A: begin
          raw_c[c] = bus_a_in;
          en_c[c]  = !sample_enable_n_in[0];
        end
        SRC_BUS_B: begin
          raw_c[c] = bus_b_in;
          en_c[c]  = !sample_enable_n_in[1];
        end
        SRC_BUS_C: begin
          raw_c[c] = bus_c_in;
          en_c[c]  = !sample_enable_n_in[2];
        end
        SRC_BUS_D: begin
          raw_c[c] = bus_d_in;
          en_c[c]  = !sample_enable_n_in[3];
        end
        default: begin
          raw_c[c] = test_data_q;
          // Static enable lets an idle channel sit still to save power
          if (cfg_q[c][B_TEST_EN_SEL]) begin
            en_c[c] = !cfg_q[c][B_TEST_EN_N];
          end else begin
            en_c[c] = test_strobe_q;
          end
        end
      endcase
    end
  end

  for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_conv
    sample_convert #(
      .IN_W      (BUS_W),
      .OW        (OUT_W)
    ) u_conv (
      .raw_in    (raw_c[gi]),
      .cfg_in    (cfg_q[gi]),
      .value_out (conv_c[gi])
    );
  end

  // ==========================================================================
  // Real/complex capture
  logic [NUM_CH-1:0] en_d1_q;
  logic [NUM_CH-1:0] en_d2_q;
  logic [NUM_CH-1:0] q_take;
  logic [NUM_CH-1:0] valid_q;
  logic [OUT_W-1:0]  i_hold_q [NUM_CH];
  logic [OUT_W-1:0]  i_q      [NUM_CH];
  logic [OUT_W-1:0]  q_q      [NUM_CH];

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      en_d1_q <= '0;
      en_d2_q <= '0;
    end else begin
      en_d1_q <= en_c;
      en_d2_q <= en_d1_q;
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      q_take[c] = cfg_q[c][B_COMPLEX] &&
                  (cfg_q[c][B_Q_NEXT] ? en_d1_q[c] : en_d2_q[c]);
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_q <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        i_hold_q[c] <= '0;
        i_q[c]      <= '0;
        q_q[c]      <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        valid_q[c] <= 1'b0;
        if (!cfg_q[c][B_COMPLEX]) begin
          if (en_c[c]) begin
            i_q[c]     <= conv_c[c];
            q_q[c]     <= '0;
            valid_q[c] <= 1'b1;
          end
        end else begin
          if (en_c[c]) begin
            i_hold_q[c] <= conv_c[c];
          end
          if (q_take[c]) begin
            i_q[c]     <= i_hold_q[c];
            // Lower sideband flips the spectrum by negating Q
            q_q[c]     <= cfg_q[c][B_SIDEBAND] ? -conv_c[c] : conv_c[c];
            valid_q[c] <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================================
  // Carrier oscillator / CIC advance (gated mode)
  logic [NUM_CH-1:0] adv_q;
  logic [NUM_CH-1:0] adv_late_q;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      adv_q      <= '0;
      adv_late_q <= '0;
    end else begin
      adv_q      <= en_c;
      adv_late_q <= adv_q;
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      sample_i_out[c]    = i_q[c];
      sample_q_out[c]    = q_q[c];
      sample_valid_out[c] = valid_q[c];
      // Legacy setting trails the data by one clock
      osc_advance_out[c] = cfg_q[c][B_REALIGN] ? adv_q[c] : adv_late_q[c];
    end
  end

  // ==========================================================================
  // Assertions (channel 0 stands for all four, except in the write checks, which also use channels 1 and 3)
  logic [31:0]      cfg0;
  logic [31:0]      cfg3;
  logic [OUT_W-1:0] conv0;
  logic             cplx0;

  assign cfg0  = cfg_q[0];
  assign cfg3  = cfg_q[3];
  assign conv0 = conv_c[0];
  assign cplx0 = cfg0[B_COMPLEX];

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  property p_route;
    (cfg_hit && chan_nib == 4'h1) |=> cfg_q[1] == $past(wr_data_in);
  endproperty
  a_route: assert property (p_route) else $error("channel write not routed");

  property p_bcast;
    (cfg_hit && chan_nib == CH_BCAST) |=> (cfg0 == $past(wr_data_in)) && (cfg3 == $past(wr_data_in));
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast write missed a channel");

  property p_ignore;
    (cfg_hit && chan_nib > 4'h3 && chan_nib < CH_BCAST) |=> $stable(cfg0) && $stable(cfg3);
  endproperty
  a_ignore: assert property (p_ignore) else $error("invalid nibble changed a channel");

  property p_strobe;
    (strobe_hit ##1 !strobe_hit) |-> test_strobe_q ##1 !test_strobe_q;
  endproperty
  a_strobe: assert property (p_strobe) else $error("test strobe not one cycle");

  property p_test_en;
    (en_c[0] == 1'b0 || cfg0[B_SRC_HI] == 1'b0 || !cfg0[B_TEST_EN_SEL] || !cfg0[B_TEST_EN_N]);
  endproperty
  a_test_en: assert property (p_test_en) else $error("disabled test input still enabled");

  property p_test_static;
    (cfg0[B_SRC_HI] && cfg0[B_TEST_EN_SEL] && !cfg0[B_TEST_EN_N] && !cplx0 && !cfg_hit)
      |=> sample_valid_out[0];
  endproperty
  a_test_static: assert property (p_test_static) else $error("static test enable ignored");

  property p_real;
    (en_c[0] && !cplx0) |=> sample_valid_out[0] && sample_q_out[0] == '0 && sample_i_out[0] == $past(conv0);
  endproperty
  a_real: assert property (p_real) else $error("real sample not captured");

  sequence s_i_late;
    en_c[0] && cplx0 && !cfg0[B_Q_NEXT] && !cfg_hit;
  endsequence
  sequence s_quiet2;
    (!en_c[0] && !cfg_hit) [*2];
  endsequence
  property p_q_late;
    s_i_late ##1 s_quiet2 |=> sample_valid_out[0] && sample_i_out[0] == $past(conv0, 3);
  endproperty
  a_q_late: assert property (p_q_late) else $error("late Q pairing wrong");

  sequence s_i_next;
    en_c[0] && cplx0 && cfg0[B_Q_NEXT] && !cfg0[B_SIDEBAND] && !cfg_hit;
  endsequence
  property p_q_next;
    s_i_next ##1 (!en_c[0] && !cfg_hit)
      |=> sample_valid_out[0] && sample_i_out[0] == $past(conv0, 2) && sample_q_out[0] == $past(conv0);
  endproperty
  a_q_next: assert property (p_q_next) else $error("next-clock Q pairing wrong");

  property p_lsb;
    (q_take[0] && cfg0[B_SIDEBAND] && !cfg_hit) |=> sample_q_out[0] == OUT_W'(-$past(conv0));
  endproperty
  a_lsb: assert property (p_lsb) else $error("lower sideband Q not negated");

  property p_src_b;
    (cfg0[B_SRC_HI:B_SRC_LO] == SRC_BUS_B && !cplx0 && !cfg0[B_FLOAT] && !cfg0[B_OFFSET_BIN]
      && !sample_enable_n_in[1] && !cfg_hit)
      |=> sample_i_out[0] == {{(OUT_W-FIX_W){$past(bus_b_in[FIX_W-1])}}, $past(bus_b_in[FIX_W-1:0])};
  endproperty
  a_src_b: assert property (p_src_b) else $error("bus B sample wrong");

  property p_offset;
    (cfg0[B_SRC_HI:B_SRC_LO] == SRC_BUS_A && !cplx0 && !cfg0[B_FLOAT] && cfg0[B_OFFSET_BIN]
      && !sample_enable_n_in[0] && !cfg_hit)
      |=> sample_i_out[0][FIX_W-1:0] == {~$past(bus_a_in[FIX_W-1]), $past(bus_a_in[FIX_W-2:0])};
  endproperty
  a_offset: assert property (p_offset) else $error("offset binary not converted");

  property p_fp_sat;
    (cfg0[B_SRC_HI:B_SRC_LO] == SRC_BUS_A && !cplx0 && cfg0[B_FLOAT] && !cfg0[B_FP_EXT]
      && cfg0[B_FP_SEL2] == 1'b0 && cfg0[B_FP_SEL_HI:B_FP_SEL_LO] == 2'h0 && !cfg0[B_OFFSET_BIN]
      && cfg0[B_SAT_HI:B_SAT_LO] == 3'h0 && !sample_enable_n_in[0] && !cfg_hit)
      |=> sample_i_out[0] == {{(OUT_W-11){$past(bus_a_in[13])}}, $past(bus_a_in[13:3])};
  endproperty
  a_fp_sat: assert property (p_fp_sat) else $error("exponent cap not applied");

  property p_adv_fast;
    (en_c[0] && cfg0[B_REALIGN] && !cfg_hit) |=> osc_advance_out[0];
  endproperty
  a_adv_fast: assert property (p_adv_fast) else $error("realigned advance missing");

  property p_adv_legacy;
    (en_c[0] && !cfg0[B_REALIGN] && !cfg_hit) ##1 !cfg_hit |=> osc_advance_out[0];
  endproperty
  a_adv_legacy: assert property (p_adv_legacy) else $error("legacy advance missing");

  property p_adv_cause;
    osc_advance_out[0] |-> $past(en_c[0]) || $past(en_c[0], 2);
  endproperty
  a_adv_cause: assert property (p_adv_cause) else $error("advance without enable");

endmodule : channel_input_select_format

//--- channel_input_select_format_tb.sv
// Self-checking bench for the four-channel input front end.
// Assumes the converter model drives the buses; inputs change at falling edges.
`timescale 1ns/1ps
module channel_input_select_format_tb;
  import input_fe_pkg::*;
  // ==========================================================================
  // Signals
  logic                           ref_clk_in = 1'b0;
  logic                           rst_in;
  logic                           wr_en_in;
  logic                           wr_global_in;
  logic [15:0]                    wr_addr_in;
  logic [31:0]                    wr_data_in;
  logic [1:0]                     rd_chan_in;
  logic [31:0]                    cfg_rd_out;
  logic [BUS_W-1:0]               bus_a, bus_b, bus_c, bus_d;
  logic [3:0]                     en_n;
  logic [NUM_CH-1:0][OUT_W-1:0]   sample_i_out;
  logic [NUM_CH-1:0][OUT_W-1:0]   sample_q_out;
  logic [NUM_CH-1:0]              sample_valid_out;
  logic [NUM_CH-1:0]              osc_advance_out;
  int                             n_mismatch = 0;
  int                             tests_run = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  adc_source_model src (
    .bus_a_out(bus_a), .bus_b_out(bus_b), .bus_c_out(bus_c), .bus_d_out(bus_d), .enable_n_out(en_n)
  );

  channel_input_select_format dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .wr_en_in(wr_en_in), .wr_global_in(wr_global_in),
    .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in), .rd_chan_in(rd_chan_in), .cfg_rd_out(cfg_rd_out),
    .bus_a_in(bus_a), .bus_b_in(bus_b), .bus_c_in(bus_c), .bus_d_in(bus_d),
    .sample_enable_n_in(en_n), .sample_i_out(sample_i_out), .sample_q_out(sample_q_out),
    .sample_valid_out(sample_valid_out), .osc_advance_out(osc_advance_out)
  );

  // ==========================================================================
  // Compare and report
  task report_and_stop;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task cmp32(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t cfg got %h exp %h", $time, g, e);
    end
  endtask : cmp32

  task cmp24(input logic [23:0] g, input logic [23:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t sample got %h exp %h", $time, g, e);
    end
  endtask : cmp24

  task cmpi(input int g, input int e);
    tests_run++;
    if (g != e) begin
      n_mismatch++;
      $display("ERROR %0t latency got %0d exp %0d", $time, g, e);
    end
  endtask : cmpi

  // ==========================================================================
  // Access tasks
  // Strobe stays up after the write; the next read or sample task lowers it,
  // so back-to-back writes never toggle it within one time step
  task wr(input logic g, input logic [15:0] a, input logic [31:0] d);
    wr_en_in     = 1'b1;
    wr_global_in = g;
    wr_addr_in   = a;
    wr_data_in   = d;
    @(negedge ref_clk_in);
  endtask : wr

  task cfg(input logic [3:0] nib, input logic [31:0] d);
    wr(1'b0, {nib, REG_INPUT_CFG}, d);
  endtask : cfg

  task rd_chk(input logic [1:0] ch, input logic [31:0] e);
    wr_en_in   = 1'b0;
    rd_chan_in = ch;
    @(negedge ref_clk_in);
    cmp32(cfg_rd_out, e);
  endtask : rd_chk

  // I on bus b with enable; Q on cycle qo; every other cycle shows the inverse
  task smp(input int ch, input int b, input logic [16:0] iv, input logic [16:0] qv, input int qo,
           input int lv, input int lo, input logic [23:0] ei, input logic [23:0] eq);
    int kv;
    int ko;
    kv = 0;
    ko = 0;
    wr_en_in = 1'b0;
    src.put(b, iv, 1'b1);
    for (int k = 1; k <= 6; k++) begin
      @(negedge ref_clk_in);
      // Last step left free so a following call drives the buses alone
      if (k < 6)
        src.put(b, (k == qo) ? qv : ~qv, 1'b0);
      if (kv == 0 && sample_valid_out[ch] === 1'b1) begin
        kv = k;
        cmp24(sample_i_out[ch], ei);
        cmp24(sample_q_out[ch], eq);
      end
      if (ko == 0 && osc_advance_out[ch] === 1'b1)
        ko = k;
    end
    cmpi(kv, lv);
    if (lo > 0)
      cmpi(ko, lo);
    if (kv == 0 && lv > 0)
      report_and_stop();
  endtask : smp

  task one(input logic [31:0] c, input logic [16:0] iv, input logic [23:0] ei);
    cfg(4'h0, c);
    smp(0, 0, iv, 17'h00000, 1, 1, 0, ei, 24'h000000);
  endtask : one

  // ==========================================================================
  // Main sequence
  initial begin
    rst_in       = 1'b1;
    wr_en_in     = 1'b0;
    wr_global_in = 1'b0;
    wr_addr_in   = 16'h0000;
    wr_data_in   = 32'h0000_0000;
    rd_chan_in   = 2'h0;
    repeat (16) @(negedge ref_clk_in);
    rst_in = 1'b0;
    for (int c = 0; c < 4; c++) rd_chk(2'(c), CFG_RESET);
    // Per-channel routing, refused nibbles, then each channel on its own bus
    for (int c = 0; c < 4; c++) cfg(4'(c), 32'h2000 * c);
    cfg(4'h4, 32'h0000_FFFF);
    cfg(4'hE, 32'h0000_FFFF);
    for (int c = 0; c < 4; c++) rd_chk(2'(c), 32'h2000 * c);
    for (int c = 0; c < 4; c++) smp(c, c, 17'h08001, 17'h0, 1, 1, 2, 24'hFF8001, 24'h0);
    // Broadcast of complex mode, Q on next clock, then lower sideband and Q two clocks later
    cfg(4'hF, 32'h00C0_0000);
    for (int c = 0; c < 4; c++) rd_chk(2'(c), 32'h00C0_0000);
    smp(0, 0, 17'h00010, 17'h00020, 1, 2, 0, 24'h000010, 24'h000020);
    cfg(4'h0, 32'h01C0_0000);
    smp(0, 0, 17'h00010, 17'h00020, 1, 2, 0, 24'h000010, 24'hFFFFE0);
    cfg(4'h0, 32'h0040_0000);
    smp(0, 0, 17'h00010, 17'h00020, 2, 3, 0, 24'h000010, 24'h000020);
    // Realigned oscillator enable and input formats
    cfg(4'h0, 32'h0020_0000);
    smp(0, 0, 17'h00005, 17'h0, 1, 1, 1, 24'h000005, 24'h0);
    one(32'h0000_0400, 17'h08000, 24'h000000);
    one(32'h0000_0400, 17'h00000, 24'hFF8000);
    one(32'h001C_0200, 17'h0000B, 24'h000008);
    one(32'h0004_0200, 17'h0000B, 24'h000002);
    one(32'h001F_0280, 17'h1FFFF, 24'hFFFFFE);
    one(32'h0000_0200, 17'h0000B, 24'h000001);
    // Channel 0 fed from bus B
    cfg(4'h0, 32'h0000_2000);
    smp(0, 1, 17'h00123, 17'h0, 1, 1, 2, 24'h000123, 24'h0);
    // Test register as source: disabled, strobed, then held enabled
    wr(1'b1, GADDR_TEST_DATA, 32'h0000_1234);
    cfg(4'h0, 32'h0000_9800);
    rd_chk(0, 32'h0000_9800);
    smp(0, 0, 17'h0, 17'h0, 1, 0, 0, 24'h0, 24'h0);
    cfg(4'h0, 32'h0000_8000);
    rd_chk(0, 32'h0000_8000);
    wr(1'b1, GADDR_TEST_STROBE, 32'h0000_0000);
    smp(0, 1, 17'h0, 17'h0, 1, 1, 0, 24'h001234, 24'h0);
    cfg(4'h0, 32'h0000_9000);
    smp(0, 1, 17'h0, 17'h0, 1, 1, 0, 24'h001234, 24'h0);
    // Mid-run reset while channel 0 runs free: outputs and setup must clear
    rst_in = 1'b1;
    @(negedge ref_clk_in);
    rst_in = 1'b0;
    cmp24(sample_i_out[0], 24'h000000);
    cmp24(24'(sample_valid_out), 24'h000000);
    for (int c = 0; c < 4; c++) rd_chk(2'(c), CFG_RESET);
    report_and_stop();
  end
endmodule : channel_input_select_format_tb

//--- input_fe_pkg.sv
// Package for the per-channel input front end: addresses, field positions,
// reset values and floating point split constants.
// Assumes one processor write port and four channels.
package input_fe_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_CH     = 4;
  localparam int BUS_W      = 17;
  localparam int FIX_W      = 16;
  localparam int OUT_W      = 24;

  // ==========================================================================
  // Addressing
  localparam int          CH_NIB_HI         = 15;
  localparam int          CH_NIB_LO         = 12;
  localparam logic [3:0]  CH_BCAST          = 4'hF;
  localparam logic [11:0] REG_INPUT_CFG     = 12'h000;
  localparam logic [15:0] GADDR_TEST_DATA   = 16'hF807;
  localparam logic [15:0] GADDR_TEST_STROBE = 16'hF808;

  // ==========================================================================
  // Input select/format register fields
  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
  localparam int          B_SIDEBAND    = 24;
  localparam int          B_Q_NEXT      = 23;
  localparam int          B_COMPLEX     = 22;
  localparam int          B_REALIGN     = 21;
  localparam int          B_SAT_HI      = 20;
  localparam int          B_SAT_LO      = 18;
  localparam int          B_FP_EXT      = 17;
  localparam int          B_FP_SEL2     = 16;
  localparam int          B_SRC_HI      = 15;
  localparam int          B_SRC_LO      = 13;
  localparam int          B_TEST_EN_SEL = 12;
  localparam int          B_TEST_EN_N   = 11;
  localparam int          B_OFFSET_BIN  = 10;
  localparam int          B_FLOAT       = 9;
  localparam int          B_FP_SEL_HI   = 8;
  localparam int          B_FP_SEL_LO   = 7;

  // Source codes; every other code selects the test register
  localparam logic [2:0]  SRC_BUS_A     = 3'h0;
  localparam logic [2:0]  SRC_BUS_B     = 3'h1;
  localparam logic [2:0]  SRC_BUS_C     = 3'h2;
  localparam logic [2:0]  SRC_BUS_D     = 3'h3;

  // ==========================================================================
  // Floating point split
  localparam logic [4:0]  MANT_MIN      = 5'h0B;
  localparam logic [4:0]  MANT_MAX_STD  = 5'h0D;
  localparam logic [4:0]  MANT_MAX_EXT  = 5'h10;
  localparam logic [4:0]  MANT_TWO_EXP  = 5'h0F;
  localparam logic [2:0]  EXP_NO_LIMIT  = 3'h7;

endpackage : input_fe_pkg

//--- sample_convert.sv
// Combinational sample converter: fixed or floating point, two's complement
// or offset binary, with exponent saturation.
// Assumes the raw word has already been picked by the source select.
`timescale 1ns/1ps
module sample_convert
  import input_fe_pkg::*;
#(
  parameter int IN_W  = BUS_W,
  parameter int OW    = OUT_W
) (
  // Raw sample and its channel setup
  input  wire logic [IN_W-1:0] raw_in,
  input  wire logic [31:0]     cfg_in,
  // Converted sample
  output logic      [OW-1:0]   value_out
);

  // ==========================================================================
  // Mantissa/exponent split
  function automatic logic [4:0] mant_width(input logic [31:0] cfg);
    logic [2:0] code;
    logic [4:0] w;
    code = {cfg[B_FP_SEL2], cfg[B_FP_SEL_HI:B_FP_SEL_LO]};
    w    = MANT_MIN + 5'(code);
    if (cfg[B_FP_EXT]) begin
      mant_width = (w > MANT_MAX_EXT) ? MANT_MAX_EXT : w;
    end else begin
      mant_width = (w > MANT_MAX_STD) ? MANT_MAX_STD : w;
    end
  endfunction : mant_width

  function automatic logic [4:0] exp_width(input logic [4:0] m);
    if (m == MANT_MAX_EXT) begin
      exp_width = 5'h01;
    end else if (m == MANT_TWO_EXP) begin
      exp_width = 5'h02;
    end else begin
      exp_width = 5'h03;
    end
  endfunction : exp_width

  logic [4:0]      m_w;
  logic [4:0]      e_w;
  logic [IN_W-1:0] fld;
  logic [IN_W-1:0] mant;
  logic [2:0]      ex;
  logic [FIX_W-1:0] fx;

  always_comb begin
    m_w = mant_width(cfg_in);
    e_w = exp_width(m_w);
    fld = raw_in >> e_w;
    fx  = raw_in[FIX_W-1:0];
    if (cfg_in[B_OFFSET_BIN]) begin
      fld = fld ^ (IN_W'(1) << (m_w - 5'h01));
      fx[FIX_W-1] = ~fx[FIX_W-1];
    end
    mant = IN_W'($signed(IN_W'(fld << (5'(IN_W) - m_w))) >>> (5'(IN_W) - m_w));
    ex   = raw_in[2:0] & 3'((4'h1 << e_w) - 4'h1);
    // Caps bad exponents so a large CIC shift cannot overflow downstream
    if (ex > cfg_in[B_SAT_HI:B_SAT_LO]) begin
      ex = cfg_in[B_SAT_HI:B_SAT_LO];
    end
    if (cfg_in[B_FLOAT]) begin
      value_out = {{(OW-IN_W){mant[IN_W-1]}}, mant} << ex;
    end else begin
      value_out = {{(OW-FIX_W){fx[FIX_W-1]}}, fx};
    end
  end

endmodule : sample_convert
